// ===== fabric_neighbour.sv
// Purpose: stand-in for the fabric tile below and the previous chained slice
// Assumes: the bench commands which carry and sign bits the neighbours present
// Notes:   the bits change only just after a rising edge, as a registered neighbour would
`timescale 1ns/1ps

module fabric_neighbour (
  input  wire logic       core_clk, // slice clock
  input  wire logic [2:0] cmd,      // wanted {cascade carry, tile carry, sign}
  output logic      [2:0] nbr       // presented {cascade carry, tile carry, sign}
);

  // neighbour outputs, launched one edge after the command; unknown only before the first edge
  always @(posedge core_clk) begin
    nbr <= cmd;
  end

endmodule // fabric_neighbour

// ===== split_mac.sv
// Purpose: hard multiply-accumulate slice with split halves
// Assumes: one clock, synchronous active-high reset, classic wishbone
// Notes:   configuration is a wishbone register; per-half controls are pins
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "split_mac_defines.svh"

module split_mac
  import split_mac_pkg::*;
(
  input  wire logic                    core_clk,               // slice clock
  input  wire logic                    reset,                  // sync reset, high
  input  wire logic                    wb_cyc_i,               // bus cycle
  input  wire logic                    wb_stb_i,               // bus strobe
  input  wire logic                    wb_we_i,                // bus write
  input  wire logic [`SMAC_ADR_W-1:0]  wb_adr_i,               // byte address
  input  wire logic [`SMAC_SEL_W-1:0]  wb_sel_i,               // byte lanes
  input  wire logic [`SMAC_DAT_W-1:0]  wb_dat_i,               // write data
  output logic      [`SMAC_DAT_W-1:0]  wb_dat_o,               // read data
  output logic                         wb_ack_o,               // acknowledge
  input  wire logic                    slice_enable,           // update enable
  input  wire logic [`SMAC_HALF_W-1:0] op_a,                   // multiplicand
  input  wire logic [`SMAC_HALF_W-1:0] op_b,                   // multiplier
  input  wire logic [`SMAC_HALF_W-1:0] op_c,                   // upper load value
  input  wire logic [`SMAC_HALF_W-1:0] op_d,                   // lower load value
  input  wire logic                    upper_acc_load_port,    // 1 load upper
  input  wire logic                    upper_add_sub_port,     // 1 subtract upper
  input  wire logic                    lower_acc_hold_port,    // 1 hold lower
  input  wire logic                    lower_acc_clear_port,   // 1 clear lower
  input  wire logic                    lower_acc_load_port,    // 1 load lower
  input  wire logic                    lower_add_sub_port,     // 1 subtract lower
  input  wire logic                    cascade_carry_in_port,  // from previous slice
  input  wire logic                    carry_in_lower_tile,    // from tile below
  input  wire logic                    sign_extend_from_prev,  // from previous slice
  output logic      [`SMAC_FULL_W-1:0] result,                 // slice result
  output logic                         cascade_carry_out_port, // to next slice
  output logic                         carry_out_higher_tile,  // to tile above
  output logic                         sign_extend_to_next     // to next slice
);

  // narrow multiply, low bits of an extended product
  function automatic logic [`SMAC_HALF_W-1:0] mul8(
    input logic [`SMAC_NARROW_W-1:0] x,
    input logic [`SMAC_NARROW_W-1:0] y,
    input logic                      sgn
  );
    logic [`SMAC_HALF_W-1:0] xe;
    logic [`SMAC_HALF_W-1:0] ye;
    xe   = {{`SMAC_NARROW_W{sgn & x[`SMAC_NARROW_W-1]}}, x};
    ye   = {{`SMAC_NARROW_W{sgn & y[`SMAC_NARROW_W-1]}}, y};
    mul8 = xe * ye;
  endfunction

  // full multiply, low bits of an extended product
  function automatic logic [`SMAC_FULL_W-1:0] mul16(
    input logic [`SMAC_HALF_W-1:0] x,
    input logic [`SMAC_HALF_W-1:0] y,
    input logic                    sgn
  );
    logic [`SMAC_FULL_W-1:0] xe;
    logic [`SMAC_FULL_W-1:0] ye;
    xe    = {{`SMAC_HALF_W{sgn & x[`SMAC_HALF_W-1]}}, x};
    ye    = {{`SMAC_HALF_W{sgn & y[`SMAC_HALF_W-1]}}, y};
    mul16 = xe * ye;
  endfunction

  // half adder/subtracter, top bit is carry or borrow
  function automatic logic [`SMAC_HALF_W:0] addsub16(
    input logic [`SMAC_HALF_W-1:0] x,
    input logic [`SMAC_HALF_W-1:0] y,
    input logic                    cin,
    input logic                    sub
  );
    if (sub) begin
      addsub16 = {1'b0, x} - {1'b0, y} - {{`SMAC_HALF_W{1'b0}}, cin};
    end else begin
      addsub16 = {1'b0, x} + {1'b0, y} + {{`SMAC_HALF_W{1'b0}}, cin};
    end
  endfunction

  state_t st_reg;  // registered state
  state_t st_next; // next state

  logic [`SMAC_HALF_W-1:0] a_s;      // operand a after input stage
  logic [`SMAC_HALF_W-1:0] b_s;      // operand b after input stage
  logic [`SMAC_HALF_W-1:0] c_s;      // upper load operand after input stage
  logic [`SMAC_HALF_W-1:0] d_s;      // lower load operand after input stage
  logic [`SMAC_FULL_W-1:0] prod_c;   // multiplier output
  logic [`SMAC_FULL_W-1:0] p_s;      // product after intermediate stage
  logic [`SMAC_FULL_W-1:0] y_s;      // adder summand
  logic                    cin_lo;   // lower adder carry in
  logic                    cin_hi;   // upper adder carry in
  logic [`SMAC_HALF_W:0]   sum_lo;   // lower sum with carry
  logic [`SMAC_HALF_W:0]   sum_hi;   // upper sum with carry
  logic [`SMAC_FULL_W-1:0] add_res;  // adder result as selected
  logic [`SMAC_FULL_W-1:0] acc_nx;   // accumulator next value
  logic                    bus_req;  // new bus request
  logic                    bus_wr;   // write commits this edge

  // input stage, registered or direct
  assign a_s = st_reg.cfg.in_reg ? st_reg.a : op_a;
  assign b_s = st_reg.cfg.in_reg ? st_reg.b : op_b;
  assign c_s = st_reg.cfg.in_reg ? st_reg.c : op_c;
  assign d_s = st_reg.cfg.in_reg ? st_reg.d : op_d;

  // full product or two narrow products; each half serves one 8x8
  assign prod_c = st_reg.cfg.split_mult ?
    {mul8(a_s[`SMAC_HALF_W-1:`SMAC_NARROW_W], b_s[`SMAC_HALF_W-1:`SMAC_NARROW_W],
          st_reg.cfg.sgn),
     mul8(a_s[`SMAC_NARROW_W-1:0], b_s[`SMAC_NARROW_W-1:0], st_reg.cfg.sgn)} :
    mul16(a_s, b_s, st_reg.cfg.sgn);

  // intermediate register or combinational pass
  assign p_s = st_reg.cfg.mid_reg ? st_reg.prod : prod_c;

  // summand is product, or sign extension of previous slice
  assign y_s = st_reg.cfg.ext_sel ? {`SMAC_FULL_W{sign_extend_from_prev}} : p_s;

  // lower carry from cascade chain or from tile below
  assign cin_lo = st_reg.cfg.casc_sel ? cascade_carry_in_port : carry_in_lower_tile;

  // lower adder, its carry chains into upper when joined
  assign sum_lo = addsub16(st_reg.acc[`SMAC_HALF_W-1:0], y_s[`SMAC_HALF_W-1:0],
                           cin_lo, lower_add_sub_port);
  assign cin_hi = st_reg.cfg.split_acc ? 1'b0 : sum_lo[`SMAC_HALF_W];
  assign sum_hi = addsub16(st_reg.acc[`SMAC_FULL_W-1:`SMAC_HALF_W],
                           y_s[`SMAC_FULL_W-1:`SMAC_HALF_W],
                           cin_hi, upper_add_sub_port);

  // combinational sum or accumulator register
  assign add_res = st_reg.cfg.acc_comb ?
    {sum_hi[`SMAC_HALF_W-1:0], sum_lo[`SMAC_HALF_W-1:0]} : st_reg.acc;

  // accumulator next value per half
  always_comb begin
    acc_nx = st_reg.acc;
    // upper half: load C or take sum
    if (upper_acc_load_port) begin
      acc_nx[`SMAC_FULL_W-1:`SMAC_HALF_W] = c_s;
    end else begin
      acc_nx[`SMAC_FULL_W-1:`SMAC_HALF_W] = sum_hi[`SMAC_HALF_W-1:0];
    end
    // lower half: clear beats hold beats load
    if (lower_acc_clear_port) begin
      acc_nx[`SMAC_HALF_W-1:0] = {`SMAC_HALF_W{1'b0}};
    end else if (lower_acc_hold_port) begin
      acc_nx[`SMAC_HALF_W-1:0] = st_reg.acc[`SMAC_HALF_W-1:0];
    end else if (lower_acc_load_port) begin
      acc_nx[`SMAC_HALF_W-1:0] = d_s;
    end else begin
      acc_nx[`SMAC_HALF_W-1:0] = sum_lo[`SMAC_HALF_W-1:0];
    end
  end

  // bus request and write commit at the acknowledged edge
  assign bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign bus_wr  = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack &
                   (wb_adr_i == `SMAC_CFG_ADDR);

  // next state of the whole slice
  always_comb begin
    st_next     = st_reg;
    st_next.ack = bus_req;
    // datapath advances only when enabled
    if (slice_enable) begin
      st_next.a     = op_a;
      st_next.b     = op_b;
      st_next.c     = op_c;
      st_next.d     = op_d;
      st_next.prod  = prod_c;
      st_next.acc   = acc_nx;
      st_next.outq  = add_res;
      st_next.ccas  = sum_hi[`SMAC_HALF_W];
      st_next.ctile = st_reg.cfg.split_acc ? sum_lo[`SMAC_HALF_W] :
                      sum_hi[`SMAC_HALF_W];
      st_next.sext  = st_reg.cfg.sgn & acc_nx[`SMAC_FULL_W-1];
    end
    // configuration write by byte lane
    if (bus_wr) begin
      if (wb_sel_i[`SMAC_SEL_LANE0]) begin
        st_next.cfg[`SMAC_LANE0_HI:0] = wb_dat_i[`SMAC_LANE0_HI:0];
      end
      if (wb_sel_i[`SMAC_SEL_LANE1]) begin
        st_next.cfg[`SMAC_CFG_TOP:`SMAC_LANE1_LO] =
          wb_dat_i[`SMAC_CFG_TOP:`SMAC_LANE1_LO];
      end
    end
    // read data captured with the request
    if (bus_req) begin
      if (wb_adr_i == `SMAC_CFG_ADDR) begin
        st_next.rdata = {`SMAC_CFG_PAD, st_reg.cfg};
      end else if (wb_adr_i == `SMAC_RESULT_ADDR) begin
        st_next.rdata = result;
      end else if (wb_adr_i == `SMAC_PROD_ADDR) begin
        st_next.rdata = p_s;
      end else if (wb_adr_i == `SMAC_FLAGS_ADDR) begin
        st_next.rdata = {`SMAC_FLAGS_PAD, st_reg.sext, st_reg.ctile, st_reg.ccas};
      end else begin
        st_next.rdata = `SMAC_RD_NONE;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg     <= '0;
      st_reg.cfg <= `SMAC_CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign result                 = st_reg.cfg.out_reg ? st_reg.outq : add_res;
  assign cascade_carry_out_port = st_reg.ccas;
  assign carry_out_higher_tile  = st_reg.ctile;
  assign sign_extend_to_next    = st_reg.sext;
  assign wb_dat_o               = st_reg.rdata;
  assign wb_ack_o               = st_reg.ack;

  // checks
  property p_lower_clear;
    @(posedge core_clk) disable iff (reset)
      slice_enable && lower_acc_clear_port |=> st_reg.acc[`SMAC_HALF_W-1:0] == '0;
  endproperty
  a_lower_clear: assert property (p_lower_clear) else $error("lower clear failed");

  property p_lower_hold;
    @(posedge core_clk) disable iff (reset)
      slice_enable && lower_acc_hold_port && !lower_acc_clear_port |=>
        st_reg.acc[`SMAC_HALF_W-1:0] == $past(st_reg.acc[`SMAC_HALF_W-1:0]);
  endproperty
  a_lower_hold: assert property (p_lower_hold) else $error("lower hold failed");

  property p_upper_load;
    @(posedge core_clk) disable iff (reset)
      slice_enable && upper_acc_load_port |=>
        st_reg.acc[`SMAC_FULL_W-1:`SMAC_HALF_W] == $past(c_s);
  endproperty
  a_upper_load: assert property (p_upper_load) else $error("upper load failed");

  property p_lower_load;
    @(posedge core_clk) disable iff (reset)
      slice_enable && lower_acc_load_port && !lower_acc_hold_port &&
      !lower_acc_clear_port |=> st_reg.acc[`SMAC_HALF_W-1:0] == $past(d_s);
  endproperty
  a_lower_load: assert property (p_lower_load) else $error("lower load failed");

  property p_upper_sub;
    @(posedge core_clk) disable iff (reset)
      slice_enable && !upper_acc_load_port && st_reg.cfg.split_acc &&
      upper_add_sub_port |=> st_reg.acc[`SMAC_FULL_W-1:`SMAC_HALF_W] ==
        $past(st_reg.acc[`SMAC_FULL_W-1:`SMAC_HALF_W] - y_s[`SMAC_FULL_W-1:`SMAC_HALF_W]);
  endproperty
  a_upper_sub: assert property (p_upper_sub) else $error("upper subtract failed");

  property p_lower_add;
    @(posedge core_clk) disable iff (reset)
      slice_enable && !lower_acc_clear_port && !lower_acc_hold_port &&
      !lower_acc_load_port && !lower_add_sub_port |=>
        st_reg.acc[`SMAC_HALF_W-1:0] == $past(st_reg.acc[`SMAC_HALF_W-1:0] +
          y_s[`SMAC_HALF_W-1:0] + {{`SMAC_HALF_W-1{1'b0}}, cin_lo});
  endproperty
  a_lower_add: assert property (p_lower_add) else $error("lower add failed");

  property p_joined_add;
    @(posedge core_clk) disable iff (reset)
      slice_enable && !st_reg.cfg.split_acc && !upper_acc_load_port &&
      !lower_acc_clear_port && !lower_acc_hold_port && !lower_acc_load_port &&
      !lower_add_sub_port && !upper_add_sub_port |=>
        st_reg.acc == $past(st_reg.acc + y_s + {{`SMAC_FULL_W-1{1'b0}}, cin_lo});
  endproperty
  a_joined_add: assert property (p_joined_add) else $error("carry did not chain");

  property p_idle_keep;
    @(posedge core_clk) disable iff (reset)
      !slice_enable |=> $stable(st_reg.acc) && $stable(cascade_carry_out_port);
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("update without enable");

  property p_prod_reg;
    @(posedge core_clk) disable iff (reset)
      slice_enable ##1 st_reg.cfg.mid_reg && $stable(st_reg.cfg) |->
        p_s == $past(prod_c);
  endproperty
  a_prod_reg: assert property (p_prod_reg) else $error("product stage wrong");

endmodule // split_mac

// ===== split_mac_defines.svh
// Purpose: named constants of the split multiply-accumulate slice
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef SPLIT_MAC_DEFINES_SVH
`define SPLIT_MAC_DEFINES_SVH

// wishbone geometry
`define SMAC_ADR_W       8
`define SMAC_DAT_W       32
`define SMAC_SEL_W       4

// register byte addresses
`define SMAC_CFG_ADDR    8'h00
`define SMAC_RESULT_ADDR 8'h04
`define SMAC_PROD_ADDR   8'h08
`define SMAC_FLAGS_ADDR  8'h0c

// configuration register layout
`define SMAC_CFG_W       9
`define SMAC_CFG_RESET   9'h000
`define SMAC_LANE0_HI    7
`define SMAC_LANE1_LO    8
`define SMAC_CFG_TOP     8
`define SMAC_SEL_LANE0   0
`define SMAC_SEL_LANE1   1

// datapath widths and bus read fill values
`define SMAC_HALF_W      16
`define SMAC_NARROW_W    8
`define SMAC_FULL_W      32
`define SMAC_FLAGS_PAD   29'h0000_0000
`define SMAC_CFG_PAD     23'h00_0000
`define SMAC_RD_NONE     32'h0000_0000

`endif

// ===== split_mac_pkg.sv
// Purpose: types of the split multiply-accumulate slice
// Assumes: split_mac_defines.svh supplies the widths
// Notes:   state is one packed struct, registered as a whole
`include "split_mac_defines.svh"

package split_mac_pkg;

  // configuration bits, msb first
  typedef struct packed {
    logic ext_sel;    // summand from previous slice sign extension
    logic casc_sel;   // lower carry from cascade, else from tile
    logic sgn;        // signed operands
    logic split_acc;  // two 16-bit accumulators
    logic split_mult; // two 8x8 multipliers
    logic acc_comb;   // adder result combinational
    logic out_reg;    // output register in path
    logic mid_reg;    // product register in path
    logic in_reg;     // input registers in path
  } cfg_t;

  // whole slice state
  typedef struct packed {
    cfg_t                    cfg;   // software configuration
    logic [`SMAC_HALF_W-1:0] a;     // registered operand a
    logic [`SMAC_HALF_W-1:0] b;     // registered operand b
    logic [`SMAC_HALF_W-1:0] c;     // registered upper load operand
    logic [`SMAC_HALF_W-1:0] d;     // registered lower load operand
    logic [`SMAC_FULL_W-1:0] prod;  // intermediate product register
    logic [`SMAC_FULL_W-1:0] acc;   // accumulator, upper and lower half
    logic [`SMAC_FULL_W-1:0] outq;  // output register
    logic                    ccas;  // cascade carry out
    logic                    ctile; // carry out to tile above
    logic                    sext;  // sign extension out
    logic                    ack;   // bus acknowledge
    logic [`SMAC_DAT_W-1:0]  rdata; // bus read data
  } state_t;

endpackage

// ===== split_multiply_accumulate_test.sv
// Purpose: self-checking bench of the split multiply-accumulate slice
// Assumes: bus ack one cycle after a taken request; input, product and output stages bypassed by default, accumulator registered
// Notes:   each table row loads both halves, then applies one operation
`timescale 1ns/1ps
`include "split_mac_defines.svh"

module split_multiply_accumulate_test
  import split_mac_pkg::*;
;
  // one case: config, operands, controls, neighbour bits, expected result and flags
  typedef struct packed {
    logic [8:0] cfg; logic [15:0] a; logic [15:0] b; logic [15:0] c; logic [15:0] d;
    logic [5:0] ctl; logic [2:0] nb; logic [31:0] exp; logic [2:0] fl;
  } row_t;

  // ctl is {upper load, upper sub, lower hold, lower clear, lower load, lower sub}
  localparam row_t rows [14] = '{
    '{9'h000, 16'h3, 16'h5, 16'h1, 16'h0, 6'h00, 3'h2, 32'h0001_0010, 3'h0},
    '{9'h000, 16'h2, 16'h3, 16'h1, 16'h0, 6'h11, 3'h0, 32'h0000_fffa, 3'h0},
    '{9'h000, 16'h101, 16'h100, 16'h1, 16'h1234, 6'h08, 3'h0, 32'h0002_1234, 3'h0},
    '{9'h000, 16'h101, 16'h100, 16'h1, 16'h1234, 6'h04, 3'h0, 32'h0002_0000, 3'h0},
    '{9'h000, 16'h1, 16'h1, 16'h5, 16'hffff, 6'h20, 3'h0, 32'h0005_0000, 3'h0},
    '{9'h020, 16'h1, 16'h1, 16'h1, 16'hffff, 6'h00, 3'h0, 32'h0001_0000, 3'h2},
    '{9'h030, 16'h203, 16'h405, 16'h0, 16'h0, 6'h00, 3'h0, 32'h0008_000f, 3'h0},
    '{9'h040, 16'hffff, 16'h2, 16'h0, 16'h0, 6'h00, 3'h0, 32'hffff_fffe, 3'h1},
    '{9'h020, 16'h100, 16'h100, 16'h10, 16'h0, 6'h10, 3'h0, 32'h000f_0000, 3'h0},
    '{9'h020, 16'h1, 16'h3, 16'h0, 16'h10, 6'h01, 3'h0, 32'h0000_000d, 3'h0},
    '{9'h000, 16'h1, 16'h1, 16'hffff, 16'hffff, 6'h00, 3'h0, 32'h0, 3'h6},
    '{9'h080, 16'h0, 16'h0, 16'h0, 16'h0, 6'h00, 3'h4, 32'h1, 3'h0},
    '{9'h000, 16'h0, 16'h0, 16'h0, 16'h0, 6'h00, 3'h4, 32'h0, 3'h0},
    '{9'h100, 16'h0, 16'h0, 16'h0, 16'h5, 6'h00, 3'h1, 32'h4, 3'h6}
  };

  logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, slice_enable; // bench drives
  logic [7:0]  wb_adr_i;                          // byte address
  logic [3:0]  wb_sel_i;                          // byte lanes
  logic [31:0] wb_dat_i, wb_dat_o, result, rd;    // bus data and slice result
  logic [15:0] op_a, op_b, op_c, op_d;            // operands
  logic        upper_acc_load_port, upper_add_sub_port, lower_acc_hold_port;
  logic        lower_acc_clear_port, lower_acc_load_port, lower_add_sub_port;
  logic        wb_ack_o, cascade_carry_out_port, carry_out_higher_tile, sign_extend_to_next;
  logic [2:0]  cmd, nbr;                          // neighbour command and bits
  int          error_cnt, n_checks;               // tallies

  split_mac i_split_mac (.core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .slice_enable, .op_a, .op_b, .op_c, .op_d,
    .upper_acc_load_port, .upper_add_sub_port, .lower_acc_hold_port, .lower_acc_clear_port,
    .lower_acc_load_port, .lower_add_sub_port, .cascade_carry_in_port(nbr[2]),
    .carry_in_lower_tile(nbr[1]), .sign_extend_from_prev(nbr[0]), .result,
    .cascade_carry_out_port, .carry_out_higher_tile, .sign_extend_to_next);

  fabric_neighbour i_fabric_neighbour (.core_clk(core_clk), .cmd(cmd), .nbr(nbr));

  // free-running clock, 8 ns period
  always #4 core_clk = ~core_clk;

  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // classic single bus cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      error_cnt++;
      $display("Error at %0t ns: no bus acknowledge", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  // one enabled datapath edge with given controls
  task automatic step(input logic [5:0] ctl, input row_t r);
    {upper_acc_load_port, upper_add_sub_port, lower_acc_hold_port,
     lower_acc_clear_port, lower_acc_load_port, lower_add_sub_port} <= ctl;
    op_a <= r.a;
    op_b <= r.b;
    op_c <= r.c;
    op_d <= r.d;
    slice_enable <= 1'b1;
    @(posedge core_clk);
  endtask

  // hang guard
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    $display("Error at %0t ns: watchdog expired", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    {core_clk, wb_cyc_i, wb_stb_i, wb_we_i, slice_enable, wb_adr_i, wb_dat_i} = '0;
    {op_a, op_b, op_c, op_d, cmd, error_cnt, n_checks} = '0;
    {upper_acc_load_port, upper_add_sub_port, lower_acc_hold_port} = 3'h0;
    {lower_acc_clear_port, lower_acc_load_port, lower_add_sub_port} = 3'h0;
    wb_sel_i = 4'hf;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    wb(1'b0, `SMAC_CFG_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    // table: load both halves, apply the operation, look one edge later
    for (int i = 0; i < 14; i++) begin
      wb(1'b1, `SMAC_CFG_ADDR, {`SMAC_CFG_PAD, rows[i].cfg}, rd);
      cmd <= rows[i].nb;
      step(6'h22, rows[i]);
      step(rows[i].ctl, rows[i]);
      slice_enable <= 1'b0;
      @(posedge core_clk);
      chk(result, rows[i].exp);
      chk({`SMAC_FLAGS_PAD, cascade_carry_out_port, carry_out_higher_tile,
           sign_extend_to_next}, {`SMAC_FLAGS_PAD, rows[i].fl});
    end
    // flag register after the last row: cascade and tile carries set, sign clear
    wb(1'b0, `SMAC_FLAGS_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_0003);
    // unmapped place: reads zero, write leaves config alone
    wb(1'b1, 8'h10, 32'h0000_01ff, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, `SMAC_CFG_ADDR, 32'h0, rd);
    chk(rd, {`SMAC_CFG_PAD, rows[13].cfg});
    // lane 0 alone: low config bits written, bit 8 keeps its value
    wb_sel_i <= 4'h1;
    wb(1'b1, `SMAC_CFG_ADDR, 32'h0000_0003, rd);
    wb_sel_i <= 4'hf;
    wb(1'b0, `SMAC_CFG_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_0103);
    // second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk(result, 32'h0);
    wb(1'b0, `SMAC_CFG_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    // combinational adder and product, no enabled edge at all
    wb(1'b1, `SMAC_CFG_ADDR, 32'h0000_0008, rd);
    op_a <= 16'h3;
    op_b <= 16'h5;
    cmd <= 3'h0;
    repeat (2) @(posedge core_clk);
    chk(result, 32'h0000_000f);
    // all three stages registered: four edges of latency, then hold
    wb(1'b1, `SMAC_CFG_ADDR, 32'h0000_0007, rd);
    slice_enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(result, 32'h0);
    @(posedge core_clk);
    chk(result, 32'h0000_000f);
    slice_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(result, 32'h0000_001e);
    wb(1'b0, `SMAC_RESULT_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_001e);
    // product register keeps the last enabled product
    wb(1'b0, `SMAC_PROD_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_000f);
    wrap_up();
  end

endmodule // split_multiply_accumulate_test
